// file: design/lse_top.sv
// Line status monitor with edge-selected interrupt events, four channels.
`timescale 1ns/10ps
// Summary of operation
// R1 - Bit 7 selects equalizer event edges.
// R2 - Bit 6 selects activate code event edges.
// R3 - Bit 5 selects deactivate code event edges.
// R4 - Bit 4 selects pattern sync event edges.
// R5 - Bit 3 selects transmit clock loss edges.
// R6 - Bit 2 selects driver fault event edges.
// R7 - Bits 1 and 0 select alarm, loss edges.
// R8 - Edge-select resets to zero, rising only.
// R9 - Registers repeat per channel every 0x40.
// R10 - Status read-only; bit 7 equalizer range.
// R11 - Activate flag sets after qualification time.
// R12 - Qualification 40 ms, or 5.1 s auto.
// R13 - Activate flag holds below 1e-2 errors.
// R14 - Activate rising edge closes remote loopback.
// R15 - Deactivate flag qualifies and holds likewise.
// R16 - Deactivate rising edge opens remote loopback.
// R17 - Sync flag follows pattern detection live.
// R18 - Tx clock loss after 70 idle cycles.
// R19 - Unmasked flag events raise interrupt per select.
// R20 - Mask one suppresses; masks reset to one.
// R21 - Loss flag shows receive signal loss.
// R22 - Transitions found against previous cycle value.
module lse_top #(
    parameter longint QUAL_SHORT = lse_pkg::QUAL_SHORT_CYC,
    parameter longint QUAL_LONG = lse_pkg::QUAL_LONG_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire lse_pkg::lse_line_s line_in,
    input wire logic [3:0] act_code_match,
    input wire logic [3:0] act_code_bit_err,
    input wire logic [3:0] deact_code_match,
    input wire logic [3:0] deact_code_bit_err,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [3:0] remote_loopback_closed,
    output logic [3:0] event_pending
);
    localparam int N = lse_pkg::NUM_CH;
    localparam int QUAL_W_L = lse_pkg::QUAL_W;

    typedef enum logic [1:0] {
        LSE_IDLE = 2'h0,
        LSE_RESP = 2'h1
    } lse_bus_e;

    typedef struct packed {
        lse_pkg::lse_line_s s1;
        lse_pkg::lse_line_s s2;
        lse_pkg::lse_line_s s3;
        logic [N-1:0][7:0] mask;
        logic [N-1:0][7:0] edge_sel;
        logic [N-1:0][7:0] control;
        logic [N-1:0][7:0] status;
        logic [N-1:0][7:0] status_prev;
        logic [N-1:0][7:0] events;
        logic [N-1:0][QUAL_W_L-1:0] act_cnt;
        logic [N-1:0][QUAL_W_L-1:0] deact_cnt;
        logic [N-1:0][6:0] act_err;
        logic [N-1:0][6:0] deact_err;
        logic [N-1:0][6:0] win_cnt;
        logic [N-1:0][6:0] txclk_idle;
        logic [N-1:0] loop_closed;
        logic [N-1:0] irq;
        lse_bus_e wstate;
        logic aw_have;
        logic w_have;
        logic [9:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [1:0] bresp;
        lse_bus_e rstate;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic aw_rdy;
        logic w_rdy;
        logic b_vld;
        logic ar_rdy;
        logic r_vld;
    } lse_state_s;

    lse_state_s st;
    lse_state_s next_st;

    // -------------------------------------------------------------------
    // Helper functions
    // -------------------------------------------------------------------
    // Decodes a byte address to channel and index; returns valid.
    function automatic logic decode(input logic [9:0] addr,
                                    output logic [1:0] ch,
                                    output logic [7:0] idx);
        ch = addr[9:8]; // R9
        idx = {2'h0, addr[7:2]};
        decode = (addr[1:0] == 2'h0);
    endfunction

    // Event detection against last cycle value, per edge select.
    function automatic logic [7:0] edge_events(input logic [7:0] cur,
                                               input logic [7:0] prev,
                                               input logic [7:0] sel);
        edge_events = (cur & ~prev) | (sel & (cur ^ prev)); // R22
    endfunction

    // Takes a level once the second and third stages agree.
    function automatic logic settle(input logic mid, input logic last,
                                    input logic held);
        settle = (mid == last) ? last : held;
    endfunction

    // Qualification counter step with tolerant error window.
    function automatic logic [QUAL_W_L-1:0] qual_step(
        input logic [QUAL_W_L-1:0] cnt, input logic match,
        input logic [QUAL_W_L-1:0] limit, input logic held,
        input logic too_many);
        if (held && !too_many)
            qual_step = cnt; // R13
        else if (held || !match)
            qual_step = '0;
        else if (cnt <= limit)
            qual_step = cnt + QUAL_W_L'(1);
        else
            qual_step = cnt;
    endfunction

    always_comb
    begin
        logic [1:0] ch;
        logic [7:0] idx;
        logic ok;
        logic [QUAL_W_L-1:0] lim;
        logic [7:0] ev;
        logic act_set;
        logic deact_set;
        logic win_end;
        ch = 2'h0;
        idx = 8'h00;
        ok = 1'b0;
        lim = '0;
        ev = 8'h00;
        act_set = 1'b0;
        deact_set = 1'b0;
        win_end = 1'b0;

        next_st = st;

        // ---------------------------------------------------------------
        // Input synchronisers
        // ---------------------------------------------------------------
        next_st.s1 = line_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;

        // ---------------------------------------------------------------
        // Status flags and events per channel
        // ---------------------------------------------------------------
        for (int c = 0; c < N; c++)
        begin
            // Selects the qualification time from the auto loop bit.
            lim = st.control[c][lse_pkg::BIT_AUTO_LOOP] ?
                  QUAL_W_L'(QUAL_LONG) : QUAL_W_L'(QUAL_SHORT); // R12
            win_end = (st.win_cnt[c] == 7'(lse_pkg::ERR_WINDOW - 1));
            next_st.win_cnt[c] = win_end ? 7'h00 : st.win_cnt[c] + 7'h01;
            next_st.act_err[c] = win_end ? 7'h00 :
                st.act_err[c] + {6'h00, act_code_bit_err[c]};
            next_st.deact_err[c] = win_end ? 7'h00 :
                st.deact_err[c] + {6'h00, deact_code_bit_err[c]};
            next_st.act_cnt[c] = qual_step(st.act_cnt[c], act_code_match[c],
                lim, st.status[c][lse_pkg::BIT_ACT],
                st.act_err[c] != 7'h00 && win_end); // R11
            next_st.deact_cnt[c] = qual_step(st.deact_cnt[c],
                deact_code_match[c], lim,
                st.status[c][lse_pkg::BIT_DEACT],
                st.deact_err[c] != 7'h00 && win_end); // R15
            act_set = st.act_cnt[c] > lim;
            deact_set = st.deact_cnt[c] > lim;

            // Counts aclk cycles since the last tx clock change.
            if (st.s3.transmit_clock_pin[c] != st.s2.transmit_clock_pin[c])
                next_st.txclk_idle[c] = 7'h00;
            else if (st.txclk_idle[c] <= 7'(lse_pkg::TXCLK_LOSS_CYC))
                next_st.txclk_idle[c] = st.txclk_idle[c] + 7'h01;
            next_st.status[c] = {
                settle(st.s2.eq_out_of_range[c], st.s3.eq_out_of_range[c],
                    st.status[c][lse_pkg::BIT_EQ]), // R10
                act_set && !(st.act_err[c] != 7'h00 && win_end),
                deact_set && !(st.deact_err[c] != 7'h00 && win_end),
                settle(st.s2.pattern_sync[c], st.s3.pattern_sync[c],
                    st.status[c][lse_pkg::BIT_SYNC]), // R17
                st.txclk_idle[c] > 7'(lse_pkg::TXCLK_LOSS_CYC), // R18
                settle(st.s2.driver_fault[c], st.s3.driver_fault[c],
                    st.status[c][lse_pkg::BIT_DRV]),
                settle(st.s2.alarm_signal[c], st.s3.alarm_signal[c],
                    st.status[c][lse_pkg::BIT_AIS]),
                settle(st.s2.signal_loss[c], st.s3.signal_loss[c],
                    st.status[c][lse_pkg::BIT_LOS])}; // R21
            next_st.status_prev[c] = st.status[c];

            // Edge select bits 7..0 each pick rising or any change.
            ev = edge_events(st.status[c], st.status_prev[c],
                             st.edge_sel[c]); // R1 R2 R3 R4 R5 R6 R7
            next_st.events[c] = st.events[c] | ev;
            next_st.irq[c] = |(st.events[c] & ~st.mask[c]); // R19 R20
            if (st.status[c][lse_pkg::BIT_ACT] &&
                !st.status_prev[c][lse_pkg::BIT_ACT])
                next_st.loop_closed[c] = 1'b1; // R14
            if (st.status[c][lse_pkg::BIT_DEACT] &&
                !st.status_prev[c][lse_pkg::BIT_DEACT])
                next_st.loop_closed[c] = 1'b0; // R16
        end

        // ---------------------------------------------------------------
        // AXI4-Lite write channel
        // ---------------------------------------------------------------
        case (st.wstate)
            LSE_IDLE:
            begin
                if (s_axi_awvalid && !st.aw_have)
                begin
                    next_st.aw_have = 1'b1;
                    next_st.aw_addr = s_axi_awaddr;
                end
                if (s_axi_wvalid && !st.w_have)
                begin
                    next_st.w_have = 1'b1;
                    next_st.w_data = s_axi_wdata;
                    next_st.w_strb = s_axi_wstrb;
                end
                if (st.aw_have && st.w_have)
                begin
                    ok = decode(st.aw_addr, ch, idx);
                    next_st.bresp = lse_pkg::RESP_OKAY;
                    if (!ok)
                        next_st.bresp = lse_pkg::RESP_SLVERR;
                    else if (idx == lse_pkg::IDX_MASK)
                    begin
                        if (st.w_strb[0])
                            next_st.mask[ch] = st.w_data[7:0];
                    end
                    else if (idx == lse_pkg::IDX_EDGE_SEL)
                    begin
                        if (st.w_strb[0])
                            next_st.edge_sel[ch] = st.w_data[7:0];
                    end
                    else if (idx == lse_pkg::IDX_EVENT)
                    begin
                        // Write one clears; a new event wins.
                        if (st.w_strb[0])
                            next_st.events[ch] = (st.events[ch] &
                                ~st.w_data[7:0]) | edge_events(
                                st.status[ch], st.status_prev[ch],
                                st.edge_sel[ch]);
                    end
                    else if (idx == lse_pkg::IDX_CONTROL)
                    begin
                        if (st.w_strb[0])
                            next_st.control[ch] = {7'h00, st.w_data[0]};
                    end
                    else if (idx != lse_pkg::IDX_STATUS)
                        next_st.bresp = lse_pkg::RESP_SLVERR;
                    next_st.aw_have = 1'b0;
                    next_st.w_have = 1'b0;
                    next_st.wstate = LSE_RESP;
                end
            end
            LSE_RESP:
            begin
                if (s_axi_bready)
                    next_st.wstate = LSE_IDLE;
            end
            default:
                next_st.wstate = LSE_IDLE;
        endcase

        // ---------------------------------------------------------------
        // AXI4-Lite read channel
        // ---------------------------------------------------------------
        case (st.rstate)
            LSE_IDLE:
            begin
                if (s_axi_arvalid)
                begin
                    ok = decode(s_axi_araddr, ch, idx);
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = lse_pkg::RESP_OKAY;
                    if (!ok)
                        next_st.rresp = lse_pkg::RESP_SLVERR;
                    else if (idx == lse_pkg::IDX_MASK)
                        next_st.rdata = {24'h000000, st.mask[ch]};
                    else if (idx == lse_pkg::IDX_EDGE_SEL)
                        next_st.rdata = {24'h000000, st.edge_sel[ch]};
                    else if (idx == lse_pkg::IDX_STATUS)
                        next_st.rdata = {24'h000000, st.status[ch]};
                    else if (idx == lse_pkg::IDX_EVENT)
                        next_st.rdata = {24'h000000, st.events[ch]};
                    else if (idx == lse_pkg::IDX_CONTROL)
                        next_st.rdata = {30'h0, st.loop_closed[ch],
                                         st.control[ch][0]};
                    else
                        next_st.rresp = lse_pkg::RESP_SLVERR;
                    next_st.rstate = LSE_RESP;
                end
            end
            LSE_RESP:
            begin
                if (s_axi_rready)
                    next_st.rstate = LSE_IDLE;
            end
            default:
                next_st.rstate = LSE_IDLE;
        endcase

        // ---------------------------------------------------------------
        // Registered handshake flags
        // ---------------------------------------------------------------
        next_st.aw_rdy = (next_st.wstate == LSE_IDLE) && !next_st.aw_have;
        next_st.w_rdy = (next_st.wstate == LSE_IDLE) && !next_st.w_have;
        next_st.b_vld = (next_st.wstate == LSE_RESP);
        next_st.ar_rdy = (next_st.rstate == LSE_IDLE);
        next_st.r_vld = (next_st.rstate == LSE_RESP);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= '0;
            for (int c = 0; c < N; c++)
            begin
                st.mask[c] <= lse_pkg::MASK_RESET; // R20
                st.edge_sel[c] <= lse_pkg::EDGE_SEL_RESET; // R8
                st.control[c] <= lse_pkg::CONTROL_RESET;
            end
            st.aw_rdy <= 1'b1;
            st.w_rdy <= 1'b1;
            st.b_vld <= 1'b0;
            st.ar_rdy <= 1'b1;
            st.r_vld <= 1'b0;
        end
        else
            st <= next_st;
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign s_axi_awready = st.aw_rdy;
    assign s_axi_wready = st.w_rdy;
    assign s_axi_bvalid = st.b_vld;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.ar_rdy;
    assign s_axi_rvalid = st.r_vld;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign remote_loopback_closed = st.loop_closed;
    assign event_pending = st.irq;
endmodule // lse_top

// file: inc/lse_pkg.sv
// Package with register map, field positions and timing counts.
package lse_pkg;
    localparam int NUM_CH = 4;
    // -------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------
    localparam logic [7:0] IDX_MASK = 8'h11;
    localparam logic [7:0] IDX_EDGE_SEL = 8'h13;
    localparam logic [7:0] IDX_STATUS = 8'h14;
    localparam logic [7:0] IDX_EVENT = 8'h16;
    localparam logic [7:0] IDX_CONTROL = 8'h17;
    localparam logic [7:0] CH_STRIDE = 8'h40;
    localparam logic [7:0] MASK_RESET = 8'hFF;
    localparam logic [7:0] EDGE_SEL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int BIT_EQ = 7;
    localparam int BIT_ACT = 6;
    localparam int BIT_DEACT = 5;
    localparam int BIT_SYNC = 4;
    localparam int BIT_TXCLK = 3;
    localparam int BIT_DRV = 2;
    localparam int BIT_AIS = 1;
    localparam int BIT_LOS = 0;
    localparam int BIT_AUTO_LOOP = 0;
    localparam int BIT_LOOP_CLOSED = 1;
    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam longint CLK_HZ = 125000000;
    localparam longint QUAL_SHORT_MS = 40;
    localparam longint QUAL_LONG_MS = 5100;
    localparam longint QUAL_SHORT_CYC = QUAL_SHORT_MS * CLK_HZ / 1000;
    localparam longint QUAL_LONG_CYC = QUAL_LONG_MS * CLK_HZ / 1000;
    localparam int TXCLK_LOSS_CYC = 70;
    localparam int ERR_WINDOW = 100;
    localparam int QUAL_W = 32;

    typedef struct packed {
        logic [NUM_CH-1:0] eq_out_of_range;
        logic [NUM_CH-1:0] activate_code;
        logic [NUM_CH-1:0] deactivate_code;
        logic [NUM_CH-1:0] pattern_sync;
        logic [NUM_CH-1:0] driver_fault;
        logic [NUM_CH-1:0] alarm_signal;
        logic [NUM_CH-1:0] signal_loss;
        logic [NUM_CH-1:0] transmit_clock_pin;
    } lse_line_s;
endpackage

// file: test/lse_properties.sv
// Bus and loopback property checker for the line status event selector.
`timescale 1ns/10ps
module lse_properties #(
    parameter longint QUAL_SHORT = 20,
    parameter longint QUAL_LONG = 40
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] act_code_match,
    input wire logic [3:0] deact_code_match,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] remote_loopback_closed
);
    // --------------------
    // Properties
    // --------------------
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    reset_idle_a: assert property (disable iff (1'b0) !aresetn |=>
        s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
        else $error("bus not idle after reset");
    write_answer_a: assert property (wr_taken |=> !s_axi_bvalid ##1
        s_axi_bvalid) else $error("write response not on time");
    read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data not on time");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready &&
        !s_axi_wready && (!s_axi_rvalid || !s_axi_arready))
        else $error("write taken during response");
    loop_close_a: assert property ((remote_loopback_closed &
        ~$past(remote_loopback_closed) & ~$past(act_code_match, 2)) == 4'h0)
        else $error("loopback closed without activate code");
    loop_open_a: assert property ($past(aresetn) |->
        (~remote_loopback_closed & $past(remote_loopback_closed) &
        ~$past(deact_code_match, 2)) == 4'h0)
        else $error("loopback opened without deactivate code");
endmodule // lse_properties

bind lse_top lse_properties #(.QUAL_SHORT(QUAL_SHORT),
    .QUAL_LONG(QUAL_LONG)) u_prop (.aclk, .aresetn, .act_code_match,
    .deact_code_match, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .remote_loopback_closed);

// file: test/line_status_event_select_tb.sv
// Self-checking bench for the line status event selector.
`timescale 1ns/10ps
module line_status_event_select_tb;
    localparam logic [9:0] MSK = {lse_pkg::IDX_MASK, 2'b00};
    localparam logic [9:0] SEL = {lse_pkg::IDX_EDGE_SEL, 2'b00};
    localparam logic [9:0] STA = {lse_pkg::IDX_STATUS, 2'b00};
    localparam logic [9:0] EVT = {lse_pkg::IDX_EVENT, 2'b00};
    localparam logic [9:0] CTL = {lse_pkg::IDX_CONTROL, 2'b00};
    localparam logic [1:0] OK = lse_pkg::RESP_OKAY;
    localparam logic [1:0] ER = lse_pkg::RESP_SLVERR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] flags = 32'h0;
    logic [3:0] txpin = 4'h0;
    logic [3:0] txrun = 4'hF;
    logic [3:0] act_code_match = 4'h0;
    logic [3:0] deact_code_match = 4'h0;
    logic [9:0] s_axi_awaddr = 10'h000;
    logic [9:0] s_axi_araddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [3:0] remote_loopback_closed, event_pending;
    logic [7:0] b;
    int miscompares = 0;
    int n_compared = 0;
    int pos[5] = '{7, 4, 2, 1, 0};
    int fld[5] = '{28, 16, 12, 8, 4};

    lse_top #(.QUAL_SHORT(20), .QUAL_LONG(40)) dut (.aclk, .aresetn,
        .line_in({flags[31:4], txpin}), .act_code_match,
        .act_code_bit_err(4'h0), .deact_code_match,
        .deact_code_bit_err(4'h0), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .remote_loopback_closed, .event_pending);

    always #4 aclk = ~aclk;
    always @(posedge aclk) txpin <= txpin ^ txrun;

    // --------------------
    // Bus tasks
    // --------------------
    function automatic logic [9:0] ad(input int c, input logic [9:0] o);
        return 10'(c * 256) + o;
    endfunction

    task automatic chk(input string w, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d,
        input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(s_axi_bvalid && s_axi_bready))
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] e,
        input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!(s_axi_rvalid && s_axi_rready))
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk($sformatf("rdata %h", a), {24'h0, e}, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    task automatic results;
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // --------------------
    // Tests
    // --------------------
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            rd(ad(c, SEL), 8'h00, OK);
            rd(ad(c, MSK), 8'hFF, OK);
            rd(ad(c, STA), 8'h00, OK);
            wr(ad(c, SEL), 8'hA0 + 8'(c), OK);
            rd(ad(c, SEL), 8'hA0 + 8'(c), OK);
        end
        wr(STA, 8'hFF, OK);
        rd(STA, 8'h00, OK);
        rd(10'h024, 8'h00, ER);
        wr(SEL + 10'h001, 8'h5A, ER);
        rd(SEL, 8'hA0, OK);
        wr(MSK, 8'h00, OK);
        for (int i = 0; i < 5; i++)
            for (int m = 0; m < 2; m++)
            begin
                b = 8'h01 << pos[i];
                wr(SEL, (m == 1) ? b : 8'h00, OK);
                flags[fld[i]] <= 1'b1;
                repeat (8) @(posedge aclk);
                rd(STA, b, OK);
                rd(EVT, b, OK);
                chk("pending", 32'h1, {31'h0, event_pending[0]});
                wr(EVT, b, OK);
                flags[fld[i]] <= 1'b0;
                repeat (8) @(posedge aclk);
                rd(EVT, (m == 1) ? b : 8'h00, OK);
                chk("pending", 32'(m), {31'h0, event_pending[0]});
                wr(EVT, 8'hFF, OK);
            end
        wr(MSK, 8'hFF, OK);
        flags[28] <= 1'b1;
        repeat (8) @(posedge aclk);
        chk("pending", 32'h0, {31'h0, event_pending[0]});
        wr(ad(1, SEL), 8'h08, OK);
        txrun[1] <= 1'b0;
        repeat (58) @(posedge aclk);
        rd(ad(1, STA), 8'h00, OK);
        repeat (20) @(posedge aclk);
        rd(ad(1, STA), 8'h08, OK);
        wr(ad(1, EVT), 8'h08, OK);
        txrun[1] <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(ad(1, STA), 8'h00, OK);
        rd(ad(1, EVT), 8'h08, OK);
        wr(ad(2, SEL), 8'h40, OK);
        act_code_match[2] <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(ad(2, STA), 8'h00, OK);
        repeat (25) @(posedge aclk);
        rd(ad(2, STA), 8'h40, OK);
        chk("closed", 32'h4, {28'h0, remote_loopback_closed});
        rd(ad(2, EVT), 8'h40, OK);
        rd(ad(2, CTL), 8'h02, OK);
        act_code_match[2] <= 1'b0;
        deact_code_match[2] <= 1'b1;
        repeat (35) @(posedge aclk);
        chk("closed", 32'h0, {28'h0, remote_loopback_closed});
        rd(ad(2, STA), 8'h60, OK);
        rd(ad(2, EVT), 8'h60, OK);
        wr(ad(3, CTL), 8'h01, OK);
        deact_code_match[3] <= 1'b1;
        repeat (30) @(posedge aclk);
        rd(ad(3, STA), 8'h00, OK);
        repeat (20) @(posedge aclk);
        rd(ad(3, STA), 8'h20, OK);
        rd(ad(3, CTL), 8'h01, OK);
        results();
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        results();
    end
endmodule // line_status_event_select_tb
